// *** hw/cas_pkg.sv ***
// cas_pkg: constants, types and carriers of the cpu alu/status datapath
// assumes one core clock; nothing here is clocked
package cas_pkg;

  // ----------------------------------------------------------------
  // register indices on the plain register port
  // ----------------------------------------------------------------
  localparam logic [3:0]  REG_STATUS  = 4'h0;  // alu_status_reg
  localparam logic [3:0]  REG_CONTROL = 4'h1;  // cpu_control_reg
  localparam logic [15:0] STAT_RESET  = 16'h0000;
  localparam logic [15:0] CTL_RESET   = 16'h0000;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SB_C   = 0;   // carry / not-borrow
  localparam int SB_Z   = 1;   // zero
  localparam int SB_OV  = 2;   // signed overflow
  localparam int SB_N   = 3;   // negative
  localparam int SB_RA  = 4;   // loop active
  localparam int SB_IPL = 5;   // priority field, bits 7..5
  localparam int SB_DC  = 8;   // half carry
  localparam int CB_PSV = 2;   // program window enable
  localparam int CB_IP3 = 3;   // priority extension
  localparam logic [15:0] STAT_IMPL = 16'h01FF;  // bits 15..9 unimplemented
  localparam logic [15:0] CTL_IMPL  = 16'h000C;
  localparam logic [2:0]  PRIO_TOP  = 3'h7;      // user interrupts off

  // ----------------------------------------------------------------
  // divider timing
  // ----------------------------------------------------------------
  localparam logic [4:0] DIV_STEPS = 5'h10;  // one step per divisor bit

  // ----------------------------------------------------------------
  // operation codes and modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_ADD = 4'b0000, OP_SUB = 4'b0001, OP_AND = 4'b0010,
    OP_IOR = 4'b0011, OP_XOR = 4'b0100, OP_SL  = 4'b0101,
    OP_LSR = 4'b0110, OP_ASR = 4'b0111, OP_MUL = 4'b1000
  } cas_op_t;

  typedef enum logic [2:0] {
    MUL_SS = 3'b000, MUL_UU = 3'b001, MUL_SU = 3'b010,
    MUL_US = 3'b011, MUL_SL = 3'b100, MUL_UL = 3'b101,
    MUL_BB = 3'b110
  } cas_mul_t;

  typedef enum logic [1:0] {
    DV_IDLE = 2'b00, DV_RUN = 2'b01, DV_FIX = 2'b10
  } cas_dv_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;    // one-cycle request
    cas_op_t     op;
    logic        byteOp;   // 1 = byte width
    logic        srcMem;   // operand a from data memory
    logic        dstMem;   // result to data memory
    cas_mul_t    mulMode;
    logic [15:0] wregVal;  // operand a from working registers
    logic [15:0] memVal;   // operand a from data memory
    logic [15:0] opB;      // operand b / literal / shift count
  } cas_req_t;

  typedef struct packed {
    logic        start;
    logic        sgn;      // signed divide
    logic        long;     // 32-bit dividend from odd:even pair
    logic [31:0] dividend;
    logic [15:0] divisor;
  } cas_div_t;

endpackage

// *** hw/cas_alu.sv ***
// cas_alu: 16-bit alu, multiplier, divider, shifter, status and control
// assumes the decoder gives one-cycle requests and reads answers next cycle
//
// Operation
// - half carry from bit 3 byte, 7 word
// - priority field codes levels 0..7 binary
// - full level is extension bit over field
// - nesting disable freezes software priority field writes
// - loop flag mirrors repeat loop, read-only
// - negative flag follows result sign
// - overflow flag on signed arithmetic overflow
// - zero flag cleared by non-zero results
// - carry flag from carry out of msb
// - subtraction carries are active-low borrows
// - extension bit: hardware sets, software only clears
// - program window enable bit, read/write
// - 16-bit datapath, byte or word ops
// - operands and results: registers or memory
// - 17x17 multiplier, all product modes
// - quotient to reg zero, remainder reg one
// - any divisor, dividend from register pair
// - divider one cycle per divisor bit
// - barrel shift up to 15 in one cycle
// - multi-bit shifts use registers only; single-bit shift results stay in registers too
// - unimplemented bits read as zero
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module cas_alu (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // register port
  input  wire logic [3:0]       regAddr,
  input  wire logic [15:0]      regWdata,
  input  wire logic             regWr,
  input  wire logic             regRd,
  output logic      [15:0]      regRdata_ff,
  // alu request and result
  input  wire cas_pkg::cas_req_t aluReq,
  output logic      [31:0]      resData_ff,
  output logic                  resValid_ff,
  output logic                  resToMem_ff,
  // divider
  input  wire cas_pkg::cas_div_t divReq,
  output logic      [15:0]      workRegZero_ff,
  output logic      [15:0]      workRegOne_ff,
  output logic                  divBusy_ff,
  output logic                  divDone_ff,
  // core state
  input  wire logic             repeatActive,
  input  wire logic             nestDisable,
  input  wire logic             hwPrioWr,
  input  wire logic [3:0]       hwPrio,
  output logic      [3:0]       prioLevel_ff,
  output logic                  userIntOff_ff,
  output logic                  progWinEn_ff
);

  // ----------------------------------------------------------------
  // operand selection and adder
  // ----------------------------------------------------------------
  logic [15:0] opA, opBx, shOut, res;   // operands and result
  logic [16:0] sum17;                   // word sum with carry
  logic [8:0]  sum9;                    // byte sum with carry
  logic [4:0]  sum5;                    // nibble sum with carry
  logic        cin, isArith, isShift, isLogic;
  logic        fC, fDc, fOv, msbA, msbB, msbR, affC;
  logic [15:0] shExt;                   // shift source, width-adjusted
  logic [3:0]  shAmt;
  logic [33:0] prod;                    // 17x17 signed product
  logic        extA, extB;
  logic [15:0] mulA, mulB;
  always_comb begin
    opA     = aluReq.srcMem ? aluReq.memVal : aluReq.wregVal;
    isArith = aluReq.op inside {cas_pkg::OP_ADD, cas_pkg::OP_SUB};
    isLogic = aluReq.op inside {cas_pkg::OP_AND, cas_pkg::OP_IOR, cas_pkg::OP_XOR};
    isShift = aluReq.op inside {cas_pkg::OP_SL, cas_pkg::OP_LSR, cas_pkg::OP_ASR};
    // subtract as a + ~b + 1 so carries come out as not-borrow
    cin   = (aluReq.op == cas_pkg::OP_SUB);
    opBx  = cin ? ~aluReq.opB : aluReq.opB;
    sum17 = {1'b0, opA} + {1'b0, opBx} + {16'h0000, cin};
    sum9  = {1'b0, opA[7:0]} + {1'b0, opBx[7:0]} + {8'h00, cin};
    sum5  = {1'b0, opA[3:0]} + {1'b0, opBx[3:0]} + {4'h0, cin};
    fDc   = aluReq.byteOp ? sum5[4] : sum9[8];
    fC    = aluReq.byteOp ? sum9[8] : sum17[16];
  end

  // ----------------------------------------------------------------
  // barrel shifter: any count 0..15 in one pass
  // ----------------------------------------------------------------
  always_comb begin
    shAmt = aluReq.opB[3:0];
    // byte shifts work on a low byte, sign-extended only for asr
    shExt = aluReq.byteOp ? {{8{(aluReq.op == cas_pkg::OP_ASR) & opA[7]}}, opA[7:0]} : opA;
    unique case (aluReq.op)
      cas_pkg::OP_SL:  shOut = shExt << shAmt;
      cas_pkg::OP_LSR: shOut = shExt >> shAmt;
      default:         shOut = 16'($signed(shExt) >>> shAmt);
    endcase
  end

  // ----------------------------------------------------------------
  // multiplier: 17x17 covers every signed/unsigned mix
  // ----------------------------------------------------------------
  always_comb begin
    mulA = (aluReq.byteOp || aluReq.mulMode == cas_pkg::MUL_BB) ? {8'h00, opA[7:0]} : opA;
    unique case (aluReq.mulMode)
      cas_pkg::MUL_SL, cas_pkg::MUL_UL: mulB = {11'h000, aluReq.opB[4:0]};
      cas_pkg::MUL_BB: mulB = {8'h00, aluReq.opB[7:0]};
      default:         mulB = aluReq.opB;
    endcase
    extA = mulA[15] & (aluReq.mulMode inside {cas_pkg::MUL_SS, cas_pkg::MUL_SU, cas_pkg::MUL_SL});
    extB = mulB[15] & (aluReq.mulMode inside {cas_pkg::MUL_SS, cas_pkg::MUL_US});
    prod = $signed({extA, mulA}) * $signed({extB, mulB});
  end

  // ----------------------------------------------------------------
  // result selection and sign/overflow bits at the active width
  // ----------------------------------------------------------------
  always_comb begin
    unique case (aluReq.op)
      cas_pkg::OP_ADD, cas_pkg::OP_SUB: res = sum17[15:0];
      cas_pkg::OP_AND: res = opA & aluReq.opB;
      cas_pkg::OP_IOR: res = opA | aluReq.opB;
      cas_pkg::OP_XOR: res = opA ^ aluReq.opB;
      default:         res = shOut;
    endcase
    // byte sign and overflow bits look only at bit 7
    msbA = aluReq.byteOp ? opA[7]  : opA[15];
    msbB = aluReq.byteOp ? opBx[7] : opBx[15];
    msbR = aluReq.byteOp ? res[7]  : res[15];
    fOv  = (msbA == msbB) & (msbR != msbA);
    // shift carry only defined for the single-bit form
    affC = isArith | (isShift & (shAmt == 4'h1));
  end

  // ----------------------------------------------------------------
  // result register: byte results other than products keep the high byte of operand a
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      resData_ff  <= 32'h0000_0000;
      resValid_ff <= 1'b0;
      resToMem_ff <= 1'b0;
    end else begin
      resValid_ff <= aluReq.valid;
      // shifts never target memory, single-bit ones included
      resToMem_ff <= aluReq.valid & aluReq.dstMem & ~isShift;
      if (aluReq.valid) begin
        if (aluReq.op == cas_pkg::OP_MUL) begin
          resData_ff <= prod[31:0];
        end else if (aluReq.byteOp) begin
          resData_ff <= {16'h0000, opA[15:8], res[7:0]};
        end else begin
          resData_ff <= {16'h0000, res};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // status and control next values
  // ----------------------------------------------------------------
  logic [15:0] stat_ff, ctl_ff, nxt_stat, nxt_ctl;
  logic [15:0] carryW;
  logic        swStat, swCtl, fire;
  always_comb begin
    swStat   = regWr & (regAddr == cas_pkg::REG_STATUS);
    swCtl    = regWr & (regAddr == cas_pkg::REG_CONTROL);
    fire     = aluReq.valid & (isArith | isLogic | isShift);
    nxt_stat = stat_ff;
    nxt_ctl  = ctl_ff;
    carryW   = regWdata;
    // software write first; priority field frozen under nesting disable
    if (swStat) begin
      if (nestDisable) begin
        carryW[cas_pkg::SB_IPL +: 3] = stat_ff[cas_pkg::SB_IPL +: 3];
      end
      nxt_stat = carryW & cas_pkg::STAT_IMPL;
    end
    // hardware updates come after, so an event beats a same-cycle write
    if (fire) begin
      nxt_stat[cas_pkg::SB_N] = msbR;
      nxt_stat[cas_pkg::SB_Z] = aluReq.byteOp ? res[7:0] == 8'h00 : res == 16'h0000;
      if (isArith) begin
        nxt_stat[cas_pkg::SB_OV] = fOv;
        nxt_stat[cas_pkg::SB_DC] = fDc;
      end
      if (affC) begin
        unique case (aluReq.op)
          cas_pkg::OP_SL: nxt_stat[cas_pkg::SB_C] = msbA;
          cas_pkg::OP_LSR, cas_pkg::OP_ASR: nxt_stat[cas_pkg::SB_C] = opA[0];
          default:        nxt_stat[cas_pkg::SB_C] = fC;
        endcase
      end
    end
    nxt_stat[cas_pkg::SB_RA] = repeatActive;
    // control: psv read/write, extension bit software-clear only
    if (swCtl) begin
      nxt_ctl[cas_pkg::CB_PSV] = regWdata[cas_pkg::CB_PSV];
      nxt_ctl[cas_pkg::CB_IP3] = nxt_ctl[cas_pkg::CB_IP3] & regWdata[cas_pkg::CB_IP3];
    end
    if (hwPrioWr) begin
      nxt_stat[cas_pkg::SB_IPL +: 3] = hwPrio[2:0];
      nxt_ctl[cas_pkg::CB_IP3]       = hwPrio[3];
    end
  end

  // ----------------------------------------------------------------
  // status / control registers and derived priority outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stat_ff       <= cas_pkg::STAT_RESET;
      ctl_ff        <= cas_pkg::CTL_RESET;
      prioLevel_ff  <= 4'h0;
      userIntOff_ff <= 1'b0;
      progWinEn_ff  <= 1'b0;
    end else begin
      stat_ff       <= nxt_stat;
      ctl_ff        <= nxt_ctl & cas_pkg::CTL_IMPL;
      prioLevel_ff  <= {nxt_ctl[cas_pkg::CB_IP3], nxt_stat[cas_pkg::SB_IPL +: 3]};
      userIntOff_ff <= nxt_ctl[cas_pkg::CB_IP3] | (nxt_stat[cas_pkg::SB_IPL +: 3] == cas_pkg::PRIO_TOP);
      progWinEn_ff  <= nxt_ctl[cas_pkg::CB_PSV];
    end
  end

  // ----------------------------------------------------------------
  // register read: data in the cycle after the strobe only
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      regRdata_ff <= 16'h0000;
    end else if (regRd && regAddr == cas_pkg::REG_STATUS) begin
      regRdata_ff <= stat_ff & cas_pkg::STAT_IMPL;
    end else if (regRd && regAddr == cas_pkg::REG_CONTROL) begin
      regRdata_ff <= ctl_ff & cas_pkg::CTL_IMPL;
    end else begin
      regRdata_ff <= 16'h0000;  // unmapped or idle
    end
  end

  // ----------------------------------------------------------------
  // divider: restoring on magnitudes, signs fixed in a last cycle
  // ----------------------------------------------------------------
  cas_pkg::cas_dv_t dvState_ff;
  logic [16:0] rem_ff, trial;       // partial remainder, trial result
  logic [15:0] quo_ff, dsr_ff;
  logic [4:0]  dvCnt_ff;
  logic        negQ_ff, negR_ff, dSgn;
  logic [31:0] dMag;
  always_comb begin
    trial = {rem_ff[15:0], quo_ff[15]} - {1'b0, dsr_ff};
    // 16-bit dividends are sign- or zero-extended to the pair width
    dSgn = divReq.sgn & (divReq.long ? divReq.dividend[31] : divReq.dividend[15]);
    dMag = divReq.long ? divReq.dividend : {{16{dSgn}}, divReq.dividend[15:0]};
    if (dSgn) begin
      dMag = -dMag;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dvState_ff     <= cas_pkg::DV_IDLE;
      rem_ff         <= 17'h00000;
      quo_ff         <= 16'h0000;
      dsr_ff         <= 16'h0000;
      dvCnt_ff       <= 5'h00;
      negQ_ff        <= 1'b0;
      negR_ff        <= 1'b0;
      divBusy_ff     <= 1'b0;
      divDone_ff     <= 1'b0;
      workRegZero_ff <= 16'h0000;
      workRegOne_ff  <= 16'h0000;
    end else begin
      divDone_ff <= 1'b0;
      unique case (dvState_ff)
        cas_pkg::DV_IDLE: begin
          if (divReq.start) begin
            rem_ff     <= {1'b0, dMag[31:16]};
            quo_ff     <= dMag[15:0];
            dsr_ff     <= (divReq.sgn && divReq.divisor[15]) ? -divReq.divisor : divReq.divisor;
            // remainder keeps the dividend sign; quotient sign is the xor of both
            negR_ff    <= dSgn;
            negQ_ff    <= dSgn ^ (divReq.sgn & divReq.divisor[15]);
            dvCnt_ff   <= 5'h00;
            divBusy_ff <= 1'b1;
            dvState_ff <= cas_pkg::DV_RUN;
          end
        end
        cas_pkg::DV_RUN: begin
          // one quotient bit per cycle, same count for both widths
          if (!trial[16]) begin
            rem_ff <= trial;
            quo_ff <= {quo_ff[14:0], 1'b1};
          end else begin
            rem_ff <= {rem_ff[15:0], quo_ff[15]};
            quo_ff <= {quo_ff[14:0], 1'b0};
          end
          dvCnt_ff <= dvCnt_ff + 5'h01;
          if (dvCnt_ff == cas_pkg::DIV_STEPS - 5'h01) begin
            dvState_ff <= cas_pkg::DV_FIX;
          end
        end
        cas_pkg::DV_FIX: begin
          workRegZero_ff <= negQ_ff ? -quo_ff : quo_ff;
          workRegOne_ff  <= negR_ff ? -rem_ff[15:0] : rem_ff[15:0];
          divBusy_ff     <= 1'b0;
          divDone_ff     <= 1'b1;
          dvState_ff     <= cas_pkg::DV_IDLE;
        end
        default: dvState_ff <= cas_pkg::DV_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_dcByte;
    aluReq.valid && aluReq.op == cas_pkg::OP_ADD && aluReq.byteOp && !hwPrioWr
      |=> stat_ff[cas_pkg::SB_DC] == ($past(opA[3:0]) + $past(aluReq.opB[3:0]) > 5'h0F);
  endproperty
  a_dcByte: assert property (p_dcByte) else $error("half carry wrong");
  property p_prio;
    prioLevel_ff == {ctl_ff[cas_pkg::CB_IP3], stat_ff[cas_pkg::SB_IPL +: 3]};
  endproperty
  a_prio: assert property (p_prio) else $error("priority level mismatch");
  property p_nest;
    swStat && nestDisable && !hwPrioWr |=> $stable(stat_ff[7:5]);
  endproperty
  a_nest: assert property (p_nest) else $error("priority field written");
  property p_loop;
    ##1 stat_ff[cas_pkg::SB_RA] == $past(repeatActive);
  endproperty
  a_loop: assert property (p_loop) else $error("loop flag wrong");
  property p_negZero;
    aluReq.valid && isArith && !aluReq.byteOp |=>
      stat_ff[cas_pkg::SB_N] == resData_ff[15] &&
      stat_ff[cas_pkg::SB_Z] == (resData_ff[15:0] == 16'h0000);
  endproperty
  a_negZero: assert property (p_negZero) else $error("n or z wrong");
  property p_ip3Clear;
    swCtl && !hwPrioWr && !ctl_ff[cas_pkg::CB_IP3] |=> !ctl_ff[cas_pkg::CB_IP3];
  endproperty
  a_ip3Clear: assert property (p_ip3Clear) else $error("extension bit set by software");
  property p_divTime;
    divReq.start && dvState_ff == cas_pkg::DV_IDLE |-> ##18 divDone_ff;
  endproperty
  a_divTime: assert property (p_divTime) else $error("divide length wrong");
  property p_shiftReg;
    aluReq.valid && isShift |=> resValid_ff && !resToMem_ff;
  endproperty
  a_shiftReg: assert property (p_shiftReg) else $error("shift went to memory");
  property p_unimpl;
    regRdata_ff[15:9] == 7'h00;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bits set");
  c_divLong:  cover property (divReq.start && divReq.long ##18 divDone_ff);
  c_byteCy:   cover property (aluReq.valid && aluReq.byteOp && isArith && fC);
  c_nestHold: cover property (swStat && nestDisable);
  c_ip3Set:   cover property (hwPrioWr && hwPrio[3]);

endmodule // cas_alu
`default_nettype wire

// *** test/cas_decoder_model.sv ***
// cas_decoder_model: decoder and working register array in front of the datapath
// assumes one core clock; one bench process calls its tasks in turn
`timescale 1ns/10ps
`default_nettype none
module cas_decoder_model (
  // clock
  input  wire logic              core_clk,
  // requests to the datapath
  output var cas_pkg::cas_req_t  aluReq,
  output var cas_pkg::cas_div_t  divReq,
  // divide answers
  input  wire logic              divDone_ff,
  input  wire logic [15:0]       workRegZero_ff,
  input  wire logic [15:0]       workRegOne_ff
);
  logic [15:0] wReg [16];  // working register array, bench preloads it
  initial begin
    aluReq = '0;
    divReq = '0;
  end
  // quotient and remainder land in the two lowest registers
  always @(posedge core_clk) begin
    if (divDone_ff === 1'b1) begin
      wReg[0] <= workRegZero_ff;
      wReg[1] <= workRegOne_ff;
    end
  end
  // one-cycle request; the unused operand path carries the inverse
  task automatic aluOp(input cas_pkg::cas_op_t op, input logic bw, sm, dm, input cas_pkg::cas_mul_t mm,
                       input logic [15:0] a, b);
    @(posedge core_clk);
    aluReq <= '{1'b1, op, bw, sm, dm, mm, sm ? ~a : a, sm ? a : ~a, b};
    @(posedge core_clk);
    aluReq.valid <= 1'b0;
  endtask
  // divisor from any register, long dividend from an aligned pair, upper half odd
  task automatic divOp(input logic sg, lg, input int m, d);
    @(posedge core_clk);
    divReq <= '{1'b1, sg, lg, {wReg[m+1], wReg[m]}, wReg[d]};
    @(posedge core_clk);
    divReq.start <= 1'b0;
  endtask
endmodule  // cas_decoder_model
`default_nettype wire

// *** test/cas_alu_test.sv ***
// cas_alu_test: self-checking bench for the alu/status datapath
// assumes cas_pkg, cas_alu and cas_decoder_model are compiled first
`timescale 1ns/10ps
`default_nettype none
module cas_alu_test;
  // ----------------------------------------------------------------
  // signals, expectation queues and counters
  // ----------------------------------------------------------------
  logic              core_clk, resValid_ff, resToMem_ff, divBusy_ff, divDone_ff, userIntOff_ff, progWinEn_ff;
  logic              rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, rdSeen = 1'b0;
  logic              repeatActive = 1'b0, nestDisable = 1'b0, hwPrioWr = 1'b0;
  logic [3:0]        regAddr = 4'h0, hwPrio = 4'h0, prioLevel_ff, k;
  logic [15:0]       regWdata = 16'h0000, regRdata_ff, workRegZero_ff, workRegOne_ff, a, b;
  logic [31:0]       resData_ff;
  cas_pkg::cas_req_t aluReq;
  cas_pkg::cas_div_t divReq;
  logic [32:0]       qRes [$];  // {to memory, data} per alu answer
  logic [15:0]       qReg [$];
  logic [31:0]       qDiv [$];  // {remainder, quotient}
  int                err_total = 0, checked = 0, n;
  cas_alu dut (.core_clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata_ff, .aluReq, .resData_ff,
               .resValid_ff, .resToMem_ff, .divReq, .workRegZero_ff, .workRegOne_ff, .divBusy_ff, .divDone_ff,
               .repeatActive, .nestDisable, .hwPrioWr, .hwPrio, .prioLevel_ff, .userIntOff_ff, .progWinEn_ff);
  cas_decoder_model pm (.core_clk, .aluReq, .divReq, .divDone_ff, .workRegZero_ff, .workRegOne_ff);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------
  // compare, verdict and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [32:0] exp, got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic regWrite(input logic [3:0] ad, input logic [15:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= ad;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic regRead(input logic [3:0] ad, input logic [15:0] e);
    qReg.push_back(e);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= ad;
    @(posedge core_clk);
    regRd <= 1'b0;
  endtask
  // shifts never target memory
  task automatic aluChk(input cas_pkg::cas_op_t op, input logic bw, input logic [15:0] x, y,
                        input logic [31:0] r, input logic [15:0] st, input logic ds,
                        input cas_pkg::cas_mul_t mm = cas_pkg::MUL_SS);
    logic sh, sm, dm;
    sh = op inside {cas_pkg::OP_SL, cas_pkg::OP_LSR, cas_pkg::OP_ASR};
    sm = sh ? 1'b0 : 1'($urandom_range(1));
    dm = 1'($urandom_range(1));
    qRes.push_back({dm & ~sh, r});
    pm.aluOp(op, bw, sm, dm, mm, x, y);
    if (ds)
      regRead(cas_pkg::REG_STATUS, st);
  endtask
  function automatic logic [31:0] mulExp(input int md, input logic [15:0] x, y);
    longint sx, ux, sy, uy;
    sx = longint'($signed(x));
    ux = longint'(x);
    sy = longint'($signed(y));
    uy = longint'(y);
    case (md)
      0: return 32'(sx * sy);
      1: return 32'(ux * uy);
      2: return 32'(sx * uy);
      3: return 32'(ux * sy);
      4: return 32'(sx * longint'(y[4:0]));
      5: return 32'(ux * longint'(y[4:0]));
      default: return 32'(longint'(x[7:0]) * longint'(y[7:0]));
    endcase
  endfunction
  task automatic divTest(input logic sg, lg, input int m, d, input logic [31:0] e);
    qDiv.push_back(e);
    pm.divOp(sg, lg, m, d);
    n = 0;
    while (n < 40 && divDone_ff !== 1'b1) begin
      @(negedge core_clk);
      n++;
      if (n == 1) chk("divider busy", 33'h1, {32'h0, divBusy_ff});
    end
    chk("divide cycles", 33'd18, 33'(n));
    if (n == 40) complete_run();
  endtask
  // ----------------------------------------------------------------
  // monitor: each answer takes the oldest note of its kind
  // ----------------------------------------------------------------
  always @(posedge core_clk) rdSeen <= regRd;
  always @(negedge core_clk) begin
    if (resValid_ff === 1'b1)
      chk("alu result", (qRes.size() > 0) ? qRes.pop_front() : 33'h1_DEAD_BEEF, {resToMem_ff, resData_ff});
    if (rdSeen === 1'b1 && qReg.size() > 0)
      chk("register read", {17'h0, qReg.pop_front()}, {17'h0, regRdata_ff});
    if (divDone_ff === 1'b1 && qDiv.size() > 0)
      chk("quotient remainder", {1'b0, qDiv.pop_front()}, {1'b0, workRegOne_ff, workRegZero_ff});
  end
  initial begin
    #1000000;
    err_total++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(57));
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    regRead(cas_pkg::REG_STATUS, 16'h0000);
    regRead(cas_pkg::REG_CONTROL, 16'h0000);
    regWrite(4'h5, 16'hFFFF);
    regRead(4'h5, 16'h0000);
    $display("reset values done");
    aluChk(cas_pkg::OP_ADD, 0, 16'h7FFF, 16'h0001, 32'h8000, 16'h010C, 1);
    aluChk(cas_pkg::OP_SUB, 0, 16'h0005, 16'h0005, 32'h0000, 16'h0103, 1);
    aluChk(cas_pkg::OP_SUB, 0, 16'h0000, 16'h0001, 32'hFFFF, 16'h0008, 1);
    aluChk(cas_pkg::OP_ADD, 1, 16'h12FF, 16'h0001, 32'h1200, 16'h0103, 1);
    aluChk(cas_pkg::OP_ADD, 1, 16'h0070, 16'h0010, 32'h0080, 16'h000C, 1);
    aluChk(cas_pkg::OP_AND, 0, 16'hF0F0, 16'h0F0F, 32'h0000, 16'h0006, 1);
    aluChk(cas_pkg::OP_IOR, 0, 16'h0F00, 16'h00F0, 32'h0FF0, 16'h0004, 1);
    aluChk(cas_pkg::OP_XOR, 0, 16'h8000, 16'h0000, 32'h8000, 16'h000C, 1);
    aluChk(cas_pkg::OP_SL, 0, 16'h8001, 16'h0001, 32'h0002, 16'h0005, 1);
    aluChk(cas_pkg::OP_LSR, 0, 16'h0001, 16'h0001, 32'h0000, 16'h0007, 1);
    aluChk(cas_pkg::OP_ASR, 0, 16'h8000, 16'h0001, 32'hC000, 16'h000C, 1);
    $display("flag operations done");
    for (int i = 0; i < 28; i++) begin
      a = 16'($urandom);
      b = 16'($urandom);
      k = 4'($urandom);
      aluChk(cas_pkg::OP_SL, 0, a, {12'h0, k}, {16'h0, a << k}, 16'h0, 0);
      aluChk(cas_pkg::OP_LSR, 0, a, {12'h0, k}, {16'h0, a >> k}, 16'h0, 0);
      aluChk(cas_pkg::OP_ASR, 0, a, {12'h0, k}, {16'h0, 16'($signed(a) >>> k)}, 16'h0, 0);
      aluChk(cas_pkg::OP_MUL, 0, a, b, mulExp(i % 7, a, b), 16'h0, 0, cas_pkg::cas_mul_t'(3'(i % 7)));
    end
    $display("shifter and multiplier done");
    pm.wReg[4] = 16'h0000;
    pm.wReg[5] = 16'h0001;
    pm.wReg[7] = 16'h0003;
    divTest(0, 1, 4, 7, 32'h0001_5555);
    pm.wReg[5] = 16'h8000;
    pm.wReg[7] = 16'hFFFE;
    divTest(0, 1, 4, 7, 32'h0002_8001);
    pm.wReg[2] = 16'hFFF9;
    pm.wReg[3] = 16'hFFFF;
    pm.wReg[6] = 16'h0002;
    divTest(1, 0, 2, 6, 32'hFFFF_FFFD);
    $display("divider done");
    nestDisable <= 1'b1;
    regWrite(cas_pkg::REG_STATUS, 16'hFFFF);
    regRead(cas_pkg::REG_STATUS, 16'h010F);
    nestDisable <= 1'b0;
    regWrite(cas_pkg::REG_STATUS, 16'h00E0);
    regRead(cas_pkg::REG_STATUS, 16'h00E0);
    @(negedge core_clk);
    chk("priority level", 33'h7, {29'h0, prioLevel_ff});
    chk("user interrupts off", 33'h1, {32'h0, userIntOff_ff});
    regWrite(cas_pkg::REG_STATUS, 16'h0000);
    @(posedge core_clk);
    hwPrioWr <= 1'b1;
    hwPrio <= 4'hA;
    @(posedge core_clk);
    hwPrioWr <= 1'b0;
    regRead(cas_pkg::REG_CONTROL, 16'h0008);
    regRead(cas_pkg::REG_STATUS, 16'h0040);
    @(negedge core_clk);
    chk("priority level", 33'hA, {29'h0, prioLevel_ff});
    chk("user interrupts off", 33'h1, {32'h0, userIntOff_ff});
    regWrite(cas_pkg::REG_CONTROL, 16'hFFFF);
    regRead(cas_pkg::REG_CONTROL, 16'h000C);
    regWrite(cas_pkg::REG_CONTROL, 16'h0004);
    regRead(cas_pkg::REG_CONTROL, 16'h0004);
    @(negedge core_clk);
    chk("priority level", 33'h2, {29'h0, prioLevel_ff});
    chk("user interrupts off", 33'h0, {32'h0, userIntOff_ff});
    chk("program window", 33'h1, {32'h0, progWinEn_ff});
    regWrite(cas_pkg::REG_CONTROL, 16'h0008);
    regRead(cas_pkg::REG_CONTROL, 16'h0000);
    repeatActive <= 1'b1;
    repeat (2) @(posedge core_clk);
    regRead(cas_pkg::REG_STATUS, 16'h0050);
    repeatActive <= 1'b0;
    repeat (2) @(posedge core_clk);
    regRead(cas_pkg::REG_STATUS, 16'h0040);
    $display("register access done");
    repeat (3) @(posedge core_clk);
    complete_run();
  end
endmodule  // cas_alu_test
`default_nettype wire
